// [dv/bmspm_top_checker.sv]
`timescale 1ns/10ps
module bmspm_top_checker
	import bmspm_pkg::*;
#(
	parameter int TICK_CYC = LAMP_TICK_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// register bus
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// pins
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [ADDR_W-1:0] wa;
	logic [31:0] wd;
	// last write taken, judged when its response rises
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wa <= '0;
			wd <= '0;
		end else begin
			if (awvalid && awready && ce) wa <= awaddr;
			if (wvalid && wready && ce) wd <= wdata;
		end
	end
	b_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response left early");
	r_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data left early");
	w_block_a: assert property (
		bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	r_block_a: assert property (
		rvalid |-> !arready)
		else $error("read taken while data pending");
	r_answer_a: assert property (
		arvalid && arready && ce |=> rvalid)
		else $error("read not answered next cycle");
	w_answer_a: assert property (
		awvalid && awready && wvalid && wready && ce |-> ##2 bvalid)
		else $error("write not answered in two cycles");
	pin_reject_a: assert property (
		$rose(bvalid) && wa[7:5] == 3'h0 && (
		(wd[4:0] == func_speed_pulse_in && wa[4:2] != PIN_SPEED) ||
		(wd[4:0] == func_charge_level_pwm && wa[4:2] != PIN_SOC) ||
		(wd[4:0] == func_current_sense_group &&
		(wa[4:2] < PIN_CUR_LO || wa[4:2] > PIN_CUR_HI)))
		|-> bresp == RESP_SLVERR)
		else $error("illegal pin selection accepted");
	bad_addr_a: assert property (
		$rose(bvalid) && wa >= 8'h34 |-> bresp == RESP_DECERR)
		else $error("unmapped write not refused");
	od_low_a: assert property (
		pin_out[7] == 1'h0)
		else $error("open-drain pin driven high");
	released_a: assert property (
		(pin_out & pin_oe_n) == 8'h00)
		else $error("released pin shows a level");
endmodule // bmspm_top_checker

bind bmspm_top bmspm_top_checker #(.TICK_CYC(TICK_CYC)) i_bmspm_top_checker (
	.clk(clk), .rstn(rstn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n));

// [dv/bmspm_top_tb.sv]
`timescale 1ns/10ps
module bmspm_top_tb
	import bmspm_pkg::*;
;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic ce = 1'h1;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0, rdata, hi, lo;
	logic [3:0] wstrb = 4'hf;
	logic [NPIN-1:0] sw = 8'h80, pin_in, pin_out, pin_oe_n;
	logic awready, wready, bvalid, arready, rvalid;
	logic sys_active, fast_charge, charge_start, leak_alarm;
	logic [1:0] bresp, rresp;
	int bad_count = 0, n_checks = 0, cyc = 0;
	// {address, config word}: inputs first, then outputs, then pin 6 as mains input
	logic [19:0] cfg [10] = '{20'h08002, 20'h0c003, 20'h1010f, 20'h14000,
		20'h0000a, 20'h08007, 20'h0c00d, 20'h1010c, 20'h14010, 20'h18003};
	// bit 31 is the mains switch, the rest goes to the state register
	logic [31:0] st [12] = '{32'h0, 32'h3, 32'h0c04, 32'h1000, 32'h2000,
		32'h4020, 32'h40, 32'h8000_0040, 32'h8000_00c0, 32'h8004_0040,
		32'h8004_0240, 32'h8000_0140};
	// lamp states: done, error with low, stage 3 with very low, no charger
	logic [31:0] lst [4] = '{32'h0000_00a0, 32'h0000_0128, 32'h0003_0030,
		32'h0000_0080};
	// high cycles per 200-cycle frame: {charging lamp, low lamp}
	logic [7:0] lexp [8] = '{8'hbe, 8'h00, 8'h64, 8'h64, 8'h1e, 8'hc8,
		8'h00, 8'h00};

	always #4 clk = ~clk;

	bmspm_top #(.TICK_CYC(10)) i_bmspm_top (.clk(clk), .rstn(rstn), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .sys_active(sys_active),
		.fast_charge(fast_charge), .charge_start(charge_start),
		.leak_alarm(leak_alarm));
	bmspm_wiring i_bmspm_wiring (.sw(sw), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in));

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ga;
		logic gw;
		ga = 1'h0;
		gw = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ga && gw)) begin
			@(posedge clk);
			if (!ga && awready) begin
				ga = 1'h1;
				awvalid <= 1'h0;
			end
			if (!gw && wready) begin
				gw = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'h0;
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'h0;
		chk(rdata, exp);
		chk(32'(rresp), 32'((a < 8'h34) ? RESP_OKAY :
			RESP_DECERR));
	endtask

	// load config entries lo..hi; the apply command is a separate step
	task automatic setup(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) wr(cfg[i][19:12], 32'(cfg[i][11:0]),
			RESP_OKAY);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		for (int i = 0; i < NPIN; i++) rd(8'(4 * i), 32'(FUNC_RST[i]));
		wr(8'h0c, 32'h01, RESP_SLVERR);
		wr(8'h08, 32'h0b, RESP_SLVERR);
		wr(8'h18, 32'h0e, RESP_SLVERR);
		wr(8'h40, 32'h00, RESP_DECERR);
		rd(OFF_STATUS, 32'h0001_0000);
		wr(OFF_STATUS, 32'h0001_0000, RESP_OKAY);
		rd(OFF_STATUS, 32'h0000_0000);
		rd(8'h40, 32'h0);
		rd(8'h0c, 32'h0e);
		setup(0, 0);
		wr(8'h10, 32'h0e, RESP_OKAY);
		rd(8'h08, 32'h0e);
		setup(0, 3);
		sw <= 8'h84;
		settle();
		chk(32'(fast_charge), 32'h0);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			sw <= {1'h1, i[3], i[0], i[2], i[1], i[0], 2'h0};
			settle();
			chk({sys_active, fast_charge, charge_start, leak_alarm},
				{i[1] | i[3], i[0], i[1], ~i[2]});
		end
		setup(4, 9);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			sw <= {1'h1, st[i][31], 6'h0};
			wr(OFF_STATE, st[i] & 32'h7fff_ffff, RESP_OKAY);
			settle();
			chk({sys_active, pin_oe_n[7]}, {st[i][31] | st[i][5],
				~st[i][0]});
			chk(pin_out[5:4], {st[i][12] | st[i][13] | st[i][14],
				st[i][10]});
			chk(pin_out[3:2], {st[i][11],
				st[i][1] | st[i][2]});
			chk(pin_out[0], st[i][31] & st[i][6] & ~st[i][7] & ~st[i][8] &
				(st[i][18:16] != 3'h4 | st[i][9]));
		end
		// one whole period after the duty is latched gives an exact count
		for (int k = 0; k < 2; k++) begin
			wr(OFF_SOC, k ? 32'h78 : 32'h25, RESP_OKAY);
			repeat (16000) @(posedge clk);
			hi = '0;
			repeat (16000) begin
				@(negedge clk);
				hi = hi + pin_out[1];
			end
			chk(hi, k ? 32'h3e80 : 32'h1720);
		end
		// lamps on pins 2 and 3; mains switch off so only bit 5 means charger
		@(posedge clk);
		sw <= 8'h80;
		wr(8'h08, 32'h09, RESP_OKAY);
		wr(8'h0c, 32'h08, RESP_OKAY);
		wr(OFF_CMD, 32'h1, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_STATE, lst[i], RESP_OKAY);
			repeat (20) @(posedge clk);
			hi = '0;
			lo = '0;
			// a window of one whole burst frame makes the count phase-free
			repeat (200) begin
				@(negedge clk);
				hi = hi + pin_out[2];
				lo = lo + pin_out[3];
			end
			chk(hi, 32'(lexp[2 * i]));
			chk(lo, 32'(lexp[2 * i + 1]));
		end
		close_out();
	end
endmodule // bmspm_top_tb

// [dv/bmspm_wiring.sv]
`timescale 1ns/10ps
module bmspm_wiring
	import bmspm_pkg::*;
(
	// switch and sensor levels set by the bench
	input wire logic [NPIN-1:0] sw,
	// block pins
	input wire logic [NPIN-1:0] pin_out,
	input wire logic [NPIN-1:0] pin_oe_n,
	output logic [NPIN-1:0] pin_in
);
	// a driven pin reads back its own level; switches show when released
	always_comb begin
		pin_in = (sw & pin_oe_n) | (pin_out & ~pin_oe_n);
		// pin 7 only sinks, so a released line follows its pull-up switch
		if (!pin_oe_n[7]) pin_in[7] = 1'h0;
	end
endmodule // bmspm_wiring

// [hw/bmspm_lamp.sv]
`timescale 1ns/10ps
module bmspm_lamp
	import bmspm_pkg::*;
#(
	parameter int TICK_CYC = LAMP_TICK_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// lamp requests and lamp levels
	bmspm_ind_if.lamp_gen ind
);
	logic [TICK_W-1:0] tcnt;
	logic tick;
	logic [4:0] frame;
	logic [2:0] bcnt;
	logic slow;
	logic fast;

	assign tick = (tcnt == TICK_W'(TICK_CYC - 1));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tcnt <= '0;
			frame <= '0;
			bcnt <= '0;
			slow <= 1'b0;
			fast <= 1'b0;
		end else if (ce) begin
			tcnt <= tick ? '0 : tcnt + 1'b1;
			if (tick) begin
				fast <= ~fast;
				frame <= (frame == BURST_LAST) ? '0 : frame + 1'b1;
				bcnt <= (bcnt == BLINK_LAST) ? '0 : bcnt + 1'b1;
				if (bcnt == BLINK_LAST) begin
					slow <= ~slow;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ind.low_lamp <= 1'b0;
			ind.chg_lamp <= 1'b0;
		end else if (ce) begin
			ind.low_lamp <= ind.vlow | (ind.low & slow);
			if (!ind.present) begin
				ind.chg_lamp <= 1'b0;
			end else if (ind.err) begin
				ind.chg_lamp <= fast;
			end else if (ind.done) begin
				ind.chg_lamp <= (frame != '0);
			end else begin
				// pulse k lights during tick 2k of each burst frame
				ind.chg_lamp <= ~frame[0] &&
					(frame[4:1] < {1'b0, ind.stage});
			end
		end
	end
endmodule // bmspm_lamp

// [hw/bmspm_pwm.sv]
`timescale 1ns/10ps
module bmspm_pwm
	import bmspm_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// soc in, pwm out
	bmspm_ind_if.pwm_gen ind
);
	logic [PRE_W-1:0] pre;
	logic [SOC_W-1:0] step;
	logic [SOC_W-1:0] duty;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre <= '0;
			step <= '0;
			duty <= SOC_RST;
			ind.pwm <= 1'b0;
		end else if (ce) begin
			pre <= (pre == PWM_PRE_LAST) ? '0 : pre + 1'b1;
			if (pre == PWM_PRE_LAST) begin
				if (step == PWM_STEP_LAST) begin
					step <= '0;
					// duty only changes at a period start, no runt pulses
					duty <= ind.soc;
				end else begin
					step <= step + 1'b1;
				end
			end
			// soc of 100 or more keeps the output high all period
			ind.pwm <= (step < duty);
		end
	end
endmodule // bmspm_pwm

// [hw/bmspm_top.sv]
`timescale 1ns/10ps
module bmspm_top
	import bmspm_pkg::*;
#(
	parameter int TICK_CYC = LAMP_TICK_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// remappable pins
	input wire logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0] pin_out,
	output logic [NPIN-1:0] pin_oe_n,
	// decoded inputs toward the controller
	output logic sys_active,
	output logic fast_charge,
	output logic charge_start,
	output logic leak_alarm
);
	bmspm_func_e pend_func [NPIN];
	bmspm_func_e act_func [NPIN];
	logic [NPIN-1:0] pend_inv;
	logic [NPIN-1:0] act_inv;
	logic [31:0] state;
	logic [SOC_W-1:0] soc;
	logic reject;
	logic dirty;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_hs, w_hs, ar_hs, b_hs, r_hs, do_write;
	logic [ADDR_W-1:0] wa;
	logic [ADDR_W-1:0] ra;
	logic [PIN_W-1:0] w_idx;
	logic wr_cfg;
	logic [31:0] cur_cfg, new_cfg;
	logic [FUNC_W-1:0] new_func;
	logic cfg_bad;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, status_word;
	logic [NPIN-1:0] sensed, drv, next_pin_out, next_pin_oe_n;
	logic [NFUNC-1:0] fin, fout;
	logic [3:0] cur_grp, cur_q;
	logic lvl_speed, lvl_mains, lvl_ign, speed_prev;
	logic [SPEED_W-1:0] speed_cnt;
	logic [STAGE_W-1:0] stage;
	logic chg_en;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		for (int b = 0; b < 4; b++) begin
			r[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic is_out(input bmspm_func_e f);
		case (f)
			func_heater_out, func_buzzer_out, func_low_charge_lamp,
			func_charging_lamp, func_charger_enable_out,
			func_charge_level_pwm, func_contactor_out, func_fan_out,
			func_power_reduce_out: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// bus handshakes; write address and data are taken in either order
	assign aw_hs = awvalid & awready;
	assign w_hs = wvalid & wready;
	assign ar_hs = arvalid & arready;
	assign b_hs = bvalid & bready;
	assign r_hs = rvalid & rready;
	assign do_write = ~awready & ~wready & ~bvalid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awready <= 1'b1;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (aw_hs) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end else if (b_hs) begin
				awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wready <= 1'b1;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce) begin
			if (w_hs) begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (b_hs) begin
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= next_bresp;
			end else if (b_hs) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= next_rdata;
				rresp <= next_rresp;
			end else if (r_hs) begin
				arready <= 1'b1;
				rvalid <= 1'b0;
			end
		end
	end

	// write decode and selection checks
	assign wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
	assign w_idx = wa[PIN_W+1:2];
	assign wr_cfg = (wa < OFF_CMD);

	always_comb begin
		cur_cfg = '0;
		cur_cfg[FUNC_W-1:0] = pend_func[w_idx];
		cur_cfg[CFG_INV_BIT] = pend_inv[w_idx];
		new_cfg = merge(cur_cfg, w_data_q, w_strb_q);
		new_func = new_cfg[FUNC_W-1:0];
		case (new_func)
			func_speed_pulse_in: cfg_bad = (w_idx != PIN_SPEED);
			func_charge_level_pwm: cfg_bad = (w_idx != PIN_SOC);
			func_current_sense_group: begin
				cfg_bad = (w_idx < PIN_CUR_LO) ||
					(w_idx > PIN_CUR_HI);
			end
			func_none, func_charge_rate_switch, func_mains_sense_in,
			func_ignition_in, func_heater_out, func_buzzer_out,
			func_low_charge_lamp, func_charging_lamp,
			func_charger_enable_out, func_contactor_out, func_fan_out,
			func_leakage_in, func_power_reduce_out: cfg_bad = 1'b0;
			default: cfg_bad = 1'b1;
		endcase
		if (wr_cfg) begin
			next_bresp = cfg_bad ? RESP_SLVERR : RESP_OKAY;
		end else begin
			case (wa)
				OFF_CMD, OFF_STATE, OFF_SOC, OFF_STATUS,
				OFF_SPEED: next_bresp = RESP_OKAY;
				default: next_bresp = RESP_DECERR;
			endcase
		end
	end

	// stored selections, taken into use only by the apply command
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NPIN; i++) begin
				pend_func[i] <= bmspm_func_e'(FUNC_RST[i]);
			end
			pend_inv <= INV_RST;
		end else if (ce && do_write && wr_cfg && !cfg_bad) begin
			if (new_func == func_current_sense_group) begin
				for (int i = PIN_CUR_LO; i <= PIN_CUR_HI; i++) begin
					pend_func[i] <= func_current_sense_group;
				end
			end else begin
				pend_func[w_idx] <= bmspm_func_e'(new_func);
			end
			pend_inv[w_idx] <= new_cfg[CFG_INV_BIT];
		end
	end

	// edits in flight never disturb the pins until the apply command
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NPIN; i++) begin
				act_func[i] <= bmspm_func_e'(FUNC_RST[i]);
			end
			act_inv <= INV_RST;
		end else if (ce && do_write && wa == OFF_CMD &&
			w_strb_q[0] && w_data_q[CMD_APPLY_BIT]) begin
			act_func <= pend_func;
			act_inv <= pend_inv;
		end
	end

	assign dirty = (act_func != pend_func) || (act_inv != pend_inv);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= STATE_RST;
			soc <= SOC_RST;
		end else if (ce && do_write) begin
			if (wa == OFF_STATE) begin
				state <= merge(state, w_data_q, w_strb_q);
			end
			if (wa == OFF_SOC) begin
				soc <= w_strb_q[0] ? w_data_q[SOC_W-1:0] : soc;
			end
		end
	end

	// a rejected selection wins over a clear in the same write slot
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reject <= 1'b0;
		end else if (ce) begin
			if (do_write && wr_cfg && cfg_bad) begin
				reject <= 1'b1;
			end else if (do_write && wa == OFF_STATUS && w_strb_q[2] &&
				w_data_q[STA_REJECT_BIT]) begin
				reject <= 1'b0;
			end
		end
	end

	// read side
	assign status_word = {14'h0000, dirty, reject, 6'h00, cur_q,
		leak_alarm, sys_active, lvl_ign, lvl_mains, fast_charge,
		lvl_speed};

	always_comb begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		ra = {araddr[ADDR_W-1:2], 2'b00};
		if (ra < OFF_CMD) begin
			next_rdata[FUNC_W-1:0] = pend_func[ra[PIN_W+1:2]];
			next_rdata[CFG_INV_BIT] = pend_inv[ra[PIN_W+1:2]];
		end else begin
			case (ra)
				OFF_CMD: next_rdata = '0;
				OFF_STATE: next_rdata = state;
				OFF_SOC: next_rdata[SOC_W-1:0] = soc;
				OFF_STATUS: next_rdata = status_word;
				OFF_SPEED: next_rdata[SPEED_W-1:0] = speed_cnt;
				default: next_rresp = RESP_DECERR;
			endcase
		end
	end

	// input functions; several pins on one function are or-ed
	assign sensed = pin_in ^ act_inv;

	always_comb begin
		fin = '0;
		cur_grp = '0;
		for (int i = 0; i < NPIN; i++) begin
			if (act_func[i] != func_none) begin
				fin[act_func[i]] = fin[act_func[i]] | sensed[i];
			end
		end
		for (int i = 0; i < 4; i++) begin
			cur_grp[i] = sensed[PIN_CUR_LO + i] &&
				(act_func[PIN_CUR_LO + i] == func_current_sense_group);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl_speed <= 1'b0;
			lvl_mains <= 1'b0;
			lvl_ign <= 1'b0;
			fast_charge <= 1'b0;
			charge_start <= 1'b0;
			leak_alarm <= 1'b0;
			sys_active <= 1'b0;
			cur_q <= '0;
		end else if (ce) begin
			lvl_speed <= fin[func_speed_pulse_in];
			lvl_mains <= fin[func_mains_sense_in];
			lvl_ign <= fin[func_ignition_in];
			fast_charge <= fin[func_charge_rate_switch];
			charge_start <= fin[func_mains_sense_in];
			leak_alarm <= fin[func_leakage_in];
			sys_active <= fin[func_ignition_in] |
				fin[func_mains_sense_in] | state[ST_CAN_MAINS];
			cur_q <= cur_grp;
		end
	end

	// speed pulses are only counted; no speed math is done here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			speed_prev <= 1'b0;
			speed_cnt <= '0;
		end else if (ce) begin
			speed_prev <= lvl_speed;
			if (lvl_speed && !speed_prev) begin
				speed_cnt <= speed_cnt + 1'b1;
			end
		end
	end

	// indicator generators
	bmspm_ind_if ind();

	assign stage = state[ST_STAGE_LSB +: STAGE_W];
	assign ind.soc = soc;
	assign ind.low = state[ST_LOW];
	assign ind.vlow = state[ST_VLOW];
	assign ind.present = lvl_mains | state[ST_CAN_MAINS];
	assign ind.stage = stage;
	assign ind.done = state[ST_CHG_DONE];
	assign ind.err = state[ST_CHG_ERR];

	bmspm_pwm u_pwm (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.ind(ind.pwm_gen)
	);

	bmspm_lamp #(
		.TICK_CYC(TICK_CYC)
	) u_lamp (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.ind(ind.lamp_gen)
	);

	// output functions
	assign chg_en = lvl_mains && state[ST_CHG_RUN] &&
		!state[ST_CHG_DONE] && !state[ST_CHG_ERR] &&
		(stage != STAGE_BALANCE || state[ST_BAL_GATE]);

	always_comb begin
		fout = '0;
		fout[func_heater_out] = state[ST_PREHEAT];
		fout[func_buzzer_out] = state[ST_WARN] | state[ST_ERR];
		fout[func_low_charge_lamp] = ind.low_lamp;
		fout[func_charging_lamp] = ind.chg_lamp;
		fout[func_charger_enable_out] = chg_en;
		fout[func_charge_level_pwm] = ind.pwm;
		fout[func_contactor_out] = ~state[ST_PROT_ERR];
		fout[func_fan_out] = state[ST_FAN_HOT];
		fout[func_power_reduce_out] =
			|state[ST_RED_HOT:ST_RED_LOWV];
	end

	always_comb begin
		drv = '0;
		next_pin_out = '0;
		next_pin_oe_n = '1;
		for (int i = 0; i < NPIN; i++) begin
			drv[i] = fout[act_func[i]] ^ act_inv[i];
			if (is_out(act_func[i])) begin
				if (PIN_OD_MASK[i]) begin
					next_pin_oe_n[i] = ~drv[i];
				end else begin
					next_pin_out[i] = drv[i];
					next_pin_oe_n[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_out <= '0;
			pin_oe_n <= '1;
		end else if (ce) begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end
endmodule // bmspm_top

// [pkg/bmspm_ind_if.sv]
`timescale 1ns/10ps
interface bmspm_ind_if
	import bmspm_pkg::*;
;
	logic [SOC_W-1:0] soc;
	logic pwm;
	logic low;
	logic vlow;
	logic present;
	logic [STAGE_W-1:0] stage;
	logic done;
	logic err;
	logic low_lamp;
	logic chg_lamp;

	modport core(output soc, low, vlow, present, stage, done, err,
		input pwm, low_lamp, chg_lamp);
	modport pwm_gen(input soc, output pwm);
	modport lamp_gen(input low, vlow, present, stage, done, err,
		output low_lamp, chg_lamp);
endinterface // bmspm_ind_if

// [pkg/bmspm_pkg.sv]
package bmspm_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int NPIN = 8;
	localparam int PIN_W = 3;
	localparam int NFUNC = 17;
	localparam int FUNC_W = 5;
	localparam int ADDR_W = 8;
	localparam int SOC_W = 7;
	localparam int STAGE_W = 3;
	localparam int SPEED_W = 16;

	typedef enum logic [FUNC_W-1:0] {
		func_none = 5'h00,
		func_speed_pulse_in = 5'h01,
		func_charge_rate_switch = 5'h02,
		func_mains_sense_in = 5'h03,
		func_ignition_in = 5'h04,
		func_heater_out = 5'h05,
		func_buzzer_out = 5'h07,
		func_low_charge_lamp = 5'h08,
		func_charging_lamp = 5'h09,
		func_charger_enable_out = 5'h0a,
		func_charge_level_pwm = 5'h0b,
		func_contactor_out = 5'h0c,
		func_fan_out = 5'h0d,
		func_current_sense_group = 5'h0e,
		func_leakage_in = 5'h0f,
		func_power_reduce_out = 5'h10
	} bmspm_func_e;

	// dedicated pins and pin types
	localparam logic [PIN_W-1:0] PIN_SPEED = 3'h0;
	localparam logic [PIN_W-1:0] PIN_SOC = 3'h1;
	localparam logic [PIN_W-1:0] PIN_CUR_LO = 3'h2;
	localparam logic [PIN_W-1:0] PIN_CUR_HI = 3'h5;
	localparam logic [NPIN-1:0] PIN_OD_MASK = 8'h80;

	// values after reset
	localparam logic [NPIN-1:0][FUNC_W-1:0] FUNC_RST = {
		func_heater_out, func_ignition_in,
		func_current_sense_group, func_current_sense_group,
		func_current_sense_group, func_current_sense_group,
		func_charge_level_pwm, func_speed_pulse_in};
	localparam logic [NPIN-1:0] INV_RST = 8'h00;
	localparam logic [31:0] STATE_RST = 32'h0000_0000;
	localparam logic [SOC_W-1:0] SOC_RST = 7'h00;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_CFG0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_SOC = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_SPEED = 8'h30;

	// field positions
	localparam int CFG_INV_BIT = 8;
	localparam int CMD_APPLY_BIT = 0;
	localparam int ST_PREHEAT = 0;
	localparam int ST_WARN = 1;
	localparam int ST_ERR = 2;
	localparam int ST_LOW = 3;
	localparam int ST_VLOW = 4;
	localparam int ST_CAN_MAINS = 5;
	localparam int ST_CHG_RUN = 6;
	localparam int ST_CHG_DONE = 7;
	localparam int ST_CHG_ERR = 8;
	localparam int ST_BAL_GATE = 9;
	localparam int ST_PROT_ERR = 10;
	localparam int ST_FAN_HOT = 11;
	localparam int ST_RED_LOWV = 12;
	localparam int ST_RED_HOT = 14;
	localparam int ST_STAGE_LSB = 16;
	localparam int STA_REJECT_BIT = 16;
	localparam logic [STAGE_W-1:0] STAGE_BALANCE = 3'h4;

	// soc pwm: 100 steps of PWM_PRE_CYC clocks
	localparam int PWM_FREQ_HZ = 7800;
	localparam int PWM_STEPS = 100;
	localparam int PWM_PRE_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
	localparam int PRE_W = 8;
	localparam logic [PRE_W-1:0] PWM_PRE_LAST = PRE_W'(PWM_PRE_CYC - 1);
	localparam logic [SOC_W-1:0] PWM_STEP_LAST = SOC_W'(PWM_STEPS - 1);

	// lamp timing, in ticks of LAMP_TICK_MS
	localparam int LAMP_TICK_MS = 100;
	localparam int LAMP_TICK_CYC = CLK_HZ / 1000 * LAMP_TICK_MS;
	localparam int TICK_W = 24;
	localparam int BURST_MS = 2000;
	localparam int LOW_BLINK_MS = 500;
	localparam logic [4:0] BURST_LAST = 5'(BURST_MS / LAMP_TICK_MS - 1);
	localparam logic [2:0] BLINK_LAST = 3'(LOW_BLINK_MS / LAMP_TICK_MS - 1);

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
